//--- tofs_regs.svh
// Register offsets, field positions and reset values of the offset and fan-sense slice
`ifndef TOFS_REGS_SVH
`define TOFS_REGS_SVH

// Register indices; byte address is four times the index
`define TOFS_IDX_REMOTE_ONE_OFS 10'h070
`define TOFS_IDX_LOCAL_OFS 10'h071
`define TOFS_IDX_REMOTE_TWO_OFS 10'h072
`define TOFS_IDX_FAN_AVG_CFG 10'h073
`define TOFS_IDX_LOCK 10'h090
`define TOFS_IDX_READ_REMOTE_ONE 10'h091
`define TOFS_IDX_READ_LOCAL 10'h092
`define TOFS_IDX_READ_REMOTE_TWO 10'h093

// Reset values
`define TOFS_RST_OFS 8'h00
`define TOFS_RST_CFG 8'h00
`define TOFS_RST_LOCK 1'h0

// Field positions in the fan-sense and averaging register
`define TOFS_CFG_SEL_LSB 0
`define TOFS_CFG_SEL_MSB 3
`define TOFS_CFG_AVG_BIT 4
`define TOFS_CFG_USED_MSB 4

// Lock register bit
`define TOFS_LOCK_BIT 0

`endif

//--- tofs_pkg.sv
// Types shared by the offset and fan-sense slice
package tofs_pkg;

	// Channel order of the three temperature paths
	typedef enum logic [1:0] {
		TOFS_CH_REMOTE_ONE,
		TOFS_CH_LOCAL,
		TOFS_CH_REMOTE_TWO
	} tofs_chan_e;

	// Stored offset, signed quarter degrees
	typedef logic signed [7:0] tofs_offset_t;

endpackage : tofs_pkg

//--- tofs_top.sv
// Temperature offset, fan-sense select and averaging control with an APB register slave
//
// Operation
// - Every remote-1 reading gets the signed remote-1 offset added, one LSB being 0.25 C.
// - Every local reading gets the signed local offset added, one LSB being 0.25 C.
// - Every remote-2 reading gets the signed remote-2 offset added, one LSB being 0.25 C.
// - After the lock bit is set, writes to the remote-1 and local offsets no longer change them.
// - The three offsets and the fan-sense/averaging register hold zero after reset.
// - A zero select bit measures that fan from the digital pulse of a 3-wire fan.
// - A one select bit senses that fan as a 2-wire fan through the coupled sense input.
// - In 2-wire mode pulses are detected against a threshold from a separate register input.
// - With averaging disabled each reading is a single conversion rather than an average.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "tofs_regs.svh"

module tofs_top #(
	parameter int TEMP_W = 10,
	parameter int AVG_LOG2 = 4,
	parameter int LVL_W = 8
) (
	input wire logic mclk, // System clock, 100 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction, high for write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [3*TEMP_W-1:0] raw_temp, // Raw conversions, remote-1 in low slice
	input wire logic [2:0] raw_valid, // Raw conversion strobe per channel
	output logic [3*TEMP_W-1:0] temp_reading, // Corrected readings for limit and fan control
	output logic [2:0] temp_reading_valid, // Pulse when a reading updates
	input wire logic [3:0] fan_speed_pulse, // Digital pulse from 3-wire fans
	input wire logic [4*LVL_W-1:0] fan_sense_level, // Sampled 2-wire sense levels
	input wire logic [LVL_W-1:0] two_wire_threshold, // Detection threshold from its own register
	output logic [3:0] fan_pulse, // Selected fan pulse per input
	output logic [3:0] fan_two_wire_select, // Select bits, high for 2-wire sensing
	output logic averaging_disable // High while averaging is off
);

	// Elaboration-time limits of the parameters
	initial begin
		if (TEMP_W < 9 || TEMP_W > 31 || AVG_LOG2 < 1 || AVG_LOG2 > 8 || LVL_W < 1) begin
			$error("tofs_top: parameter out of range");
		end
	end

	localparam int ACC_W = TEMP_W + AVG_LOG2;
	localparam logic [AVG_LOG2-1:0] CNT_LAST = {AVG_LOG2{1'b1}};
	localparam logic signed [TEMP_W:0] SAT_MAX = (TEMP_W+1)'(2 ** (TEMP_W - 1) - 1);
	localparam logic signed [TEMP_W:0] SAT_MIN = -SAT_MAX - (TEMP_W+1)'(1);

	tofs_pkg::tofs_offset_t ofs_q [3];
	logic [`TOFS_CFG_USED_MSB:0] cfg_q;
	logic lock_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [3:0] fan_pulse_q;

	// APB decode
	wire [9:0] reg_idx = paddr[11:2];
	wire aligned = paddr[1:0] == 2'h0;
	wire setup_ph = psel && !penable;
	wire wr_take = psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0];
	wire hit_ofs1 = aligned && reg_idx == `TOFS_IDX_REMOTE_ONE_OFS;
	wire hit_ofsl = aligned && reg_idx == `TOFS_IDX_LOCAL_OFS;
	wire hit_ofs2 = aligned && reg_idx == `TOFS_IDX_REMOTE_TWO_OFS;
	wire hit_cfg = aligned && reg_idx == `TOFS_IDX_FAN_AVG_CFG;
	wire hit_lock = aligned && reg_idx == `TOFS_IDX_LOCK;
	wire hit_rd1 = aligned && reg_idx == `TOFS_IDX_READ_REMOTE_ONE;
	wire hit_rdl = aligned && reg_idx == `TOFS_IDX_READ_LOCAL;
	wire hit_rd2 = aligned && reg_idx == `TOFS_IDX_READ_REMOTE_TWO;
	wire rd_only = hit_rd1 || hit_rdl || hit_rd2;
	wire hit_any = hit_ofs1 || hit_ofsl || hit_ofs2 || hit_cfg || hit_lock || rd_only;
	wire bad_access = !hit_any || (pwrite && rd_only);

	// Write enables; the first two are closed once locked
	wire we_ofs1 = wr_take && hit_ofs1 && !lock_q;
	wire we_ofsl = wr_take && hit_ofsl && !lock_q;
	wire we_ofs2 = wr_take && hit_ofs2;
	wire we_cfg = wr_take && hit_cfg;
	wire we_lock = wr_take && hit_lock && pwdata[`TOFS_LOCK_BIT];

	// Read data selection
	wire [31:0] rd_mux =
		hit_ofs1 ? {24'h000000, ofs_q[tofs_pkg::TOFS_CH_REMOTE_ONE]} :
		hit_ofsl ? {24'h000000, ofs_q[tofs_pkg::TOFS_CH_LOCAL]} :
		hit_ofs2 ? {24'h000000, ofs_q[tofs_pkg::TOFS_CH_REMOTE_TWO]} :
		hit_cfg ? {27'h0000000, cfg_q} :
		hit_lock ? {31'h00000000, lock_q} :
		hit_rd1 ? {{(32-TEMP_W){1'b0}}, temp_reading[TEMP_W-1:0]} :
		hit_rdl ? {{(32-TEMP_W){1'b0}}, temp_reading[2*TEMP_W-1:TEMP_W]} :
		hit_rd2 ? {{(32-TEMP_W){1'b0}}, temp_reading[3*TEMP_W-1:2*TEMP_W]} :
		32'h00000000;

	// Bus answer: data and ready are prepared in the setup cycle, access completes at once
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup_ph;
			pslverr_q <= setup_ph && bad_access;
			if (setup_ph) begin
				prdata_q <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	// Offset and configuration storage
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ofs_q[0] <= `TOFS_RST_OFS;
			ofs_q[1] <= `TOFS_RST_OFS;
			ofs_q[2] <= `TOFS_RST_OFS;
			cfg_q <= ($bits(cfg_q))'(`TOFS_RST_CFG);
			lock_q <= `TOFS_RST_LOCK;
		end else begin
			if (we_ofs1) ofs_q[tofs_pkg::TOFS_CH_REMOTE_ONE] <= pwdata[7:0];
			if (we_ofsl) ofs_q[tofs_pkg::TOFS_CH_LOCAL] <= pwdata[7:0];
			if (we_ofs2) ofs_q[tofs_pkg::TOFS_CH_REMOTE_TWO] <= pwdata[7:0];
			if (we_cfg) cfg_q <= pwdata[`TOFS_CFG_USED_MSB:0];
			if (we_lock) lock_q <= 1'b1; // Lock holds until reset
		end
	end

	wire avg_off = cfg_q[`TOFS_CFG_AVG_BIT];
	wire [3:0] sel_two_wire = cfg_q[`TOFS_CFG_SEL_MSB:`TOFS_CFG_SEL_LSB];

	// Per channel: optional averaging, then offset add with saturation
	for (genvar c = 0; c < 3; c++) begin : g_chan
		logic signed [ACC_W-1:0] acc_q;
		logic [AVG_LOG2-1:0] cnt_q;
		logic signed [TEMP_W-1:0] rd_q;
		logic vld_q;
		wire signed [TEMP_W-1:0] raw = raw_temp[c*TEMP_W +: TEMP_W];
		wire signed [ACC_W-1:0] raw_ext = ACC_W'(raw);
		wire signed [ACC_W-1:0] acc_sum = acc_q + raw_ext;
		wire avg_done = cnt_q == CNT_LAST;
		wire signed [TEMP_W-1:0] avg_val = TEMP_W'(acc_sum >>> AVG_LOG2);
		wire take = raw_valid[c] && (avg_off || avg_done);
		wire signed [TEMP_W-1:0] base = avg_off ? raw : avg_val;
		wire signed [TEMP_W:0] ofs_ext = (TEMP_W+1)'(ofs_q[c]);
		wire signed [TEMP_W:0] sum = (TEMP_W+1)'(base) + ofs_ext;
		wire signed [TEMP_W-1:0] sat =
			sum > SAT_MAX ? TEMP_W'(SAT_MAX) :
			sum < SAT_MIN ? TEMP_W'(SAT_MIN) :
			TEMP_W'(sum);

		// Accumulate a block of conversions unless averaging is off
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				acc_q <= '0;
				cnt_q <= '0;
			end else if (avg_off) begin
				acc_q <= '0;
				cnt_q <= '0;
			end else if (raw_valid[c]) begin
				acc_q <= avg_done ? '0 : acc_sum;
				cnt_q <= AVG_LOG2'(cnt_q + 1'b1);
			end
		end

		// Reading register holds the corrected value
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				rd_q <= '0;
				vld_q <= 1'b0;
			end else begin
				vld_q <= take;
				if (take) rd_q <= sat;
			end
		end

		assign temp_reading[c*TEMP_W +: TEMP_W] = rd_q;
		assign temp_reading_valid[c] = vld_q;
	end

	// Fan pulse source per input
	for (genvar f = 0; f < 4; f++) begin : g_fan
		wire two_wire_hit = fan_sense_level[f*LVL_W +: LVL_W] > two_wire_threshold;
		wire pulse_src = sel_two_wire[f] ? two_wire_hit : fan_speed_pulse[f];
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				fan_pulse_q[f] <= 1'b0;
			end else begin
				fan_pulse_q[f] <= pulse_src;
			end
		end
	end

	// Outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign fan_pulse = fan_pulse_q;
	assign fan_two_wire_select = sel_two_wire;
	assign averaging_disable = avg_off;

endmodule : tofs_top

//--- tofs_top_properties.sv
// Port checker of the offset and fan-sense slice
`timescale 1ns/100ps
module tofs_top_properties #(parameter int TEMP_W = 10) (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [2:0] raw_valid, // Raw strobes
	input wire logic [3*TEMP_W-1:0] temp_reading, // Readings
	input wire logic [2:0] temp_reading_valid, // Reading strobes
	input wire logic [3:0] fan_speed_pulse, // Fan pulses
	input wire logic [31:0] fan_sense_level, // Sense levels
	input wire logic [7:0] two_wire_threshold, // Threshold
	input wire logic [3:0] fan_pulse, // Chosen pulses
	input wire logic [3:0] fan_two_wire_select, // Selects
	input wire logic averaging_disable // Averaging off
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Bus answer timing, readings, fan source choice
	a_ready_access: assert property (psel && !penable |=> pready) else $error("No ready");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("Error without ready");
	a_reset_zero: assert property (disable iff (1'b0) !rst_n |=> !pready && temp_reading == 0 &&
		fan_two_wire_select == 4'h0 && !averaging_disable) else $error("Reset state wrong");
	a_three_wire_src: assert property ($past(rst_n) && !$past(fan_two_wire_select[1])
		|-> fan_pulse[1] == $past(fan_speed_pulse[1])) else $error("3-wire pulse wrong");
	a_two_wire_src: assert property ($past(rst_n) && $past(fan_two_wire_select[2])
		|-> fan_pulse[2] == ($past(fan_sense_level[23:16]) > $past(two_wire_threshold))) else $error("2-wire pulse wrong");
	a_single_conv: assert property (averaging_disable && raw_valid[0] |=> temp_reading_valid[0]) else $error("No update");
	a_update_cause: assert property (temp_reading_valid[1] |-> $past(raw_valid[1])) else $error("Stray update");
	a_reading_held: assert property ($past(rst_n) && !temp_reading_valid[2]
		|-> $stable(temp_reading[3*TEMP_W-1:2*TEMP_W])) else $error("Reading moved");
	// Main scenarios
	c_refused: cover property (pslverr);
	c_single: cover property (averaging_disable && raw_valid[0]);
	c_two_wire: cover property (fan_two_wire_select[2] && fan_pulse[2]);
endmodule : tofs_top_properties
bind tofs_top tofs_top_properties #(.TEMP_W(TEMP_W)) u_props (.mclk(mclk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_valid(raw_valid),
	.temp_reading(temp_reading), .temp_reading_valid(temp_reading_valid), .fan_speed_pulse(fan_speed_pulse),
	.fan_sense_level(fan_sense_level), .two_wire_threshold(two_wire_threshold), .fan_pulse(fan_pulse),
	.fan_two_wire_select(fan_two_wire_select), .averaging_disable(averaging_disable));

//--- tb_top.sv
// Register and reading tests of the offset and fan-sense slice
`timescale 1ns/100ps
`include "tofs_regs.svh"
module tb_top;
	logic mclk, pready, pslverr, averaging_disable, e, v;
	logic rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, fan_sense_level = 0, prdata, r;
	logic [29:0] raw_temp = 0, temp_reading;
	logic [2:0] raw_valid = 0, temp_reading_valid;
	logic [3:0] fan_speed_pulse = 0, fan_pulse, fan_two_wire_select;
	logic [9:0] t;
	logic [7:0] thr = 8'h80;
	logic [3:0] fp_exp = 4'h0;
	logic [7:0] ofs [3] = '{8'hFC, 8'h08, 8'h80};
	logic [9:0] raw [3] = '{10'd100, 10'h3EC, 10'h000};
	logic [9:0] expv [3] = '{10'd96, 10'h3F4, 10'h380};
	int mismatches = 0, check_count = 0, cycles = 0;
	tofs_top uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_temp(raw_temp),
		.raw_valid(raw_valid), .temp_reading(temp_reading), .temp_reading_valid(temp_reading_valid),
		.fan_speed_pulse(fan_speed_pulse), .fan_sense_level(fan_sense_level), .two_wire_threshold(thr),
		.fan_pulse(fan_pulse), .fan_two_wire_select(fan_two_wire_select), .averaging_disable(averaging_disable));
	// Clock
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// Moving fan inputs and the hang limit
	always @(posedge mclk) begin
		fan_speed_pulse <= fan_speed_pulse + 4'h5;
		fan_sense_level <= fan_sense_level + 32'h1D3B5977;
		for (int f = 0; f < 4; f++) begin
			fp_exp[f] <= fan_two_wire_select[f] ? (fan_sense_level[f*8 +: 8] > thr) : fan_speed_pulse[f];
		end
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			close_out();
		end
	end
	task check(input string n, input logic [31:0] s, x);
		check_count++;
		if (s !== x) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask : check
	// One APB transfer, answer taken at the edge with pready high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1 && cycles < 3000);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// One raw sample on channel c with its strobe in the same cycle, reading taken one cycle on
	task feed(input int c, input logic [9:0] x);
		@(posedge mclk);
		raw_temp[c*10 +: 10] <= x;
		raw_valid[c] <= 1;
		@(posedge mclk);
		raw_valid <= 0;
		@(negedge mclk);
		v = temp_reading_valid[c];
		t = temp_reading[c*10 +: 10];
	endtask : feed
	task close_out();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		for (int i = 0; i < 4; i++) begin
			apb(0, {`TOFS_IDX_REMOTE_ONE_OFS + 10'(i), 2'b00}, 0, r, e);
			check("reset value", r, 0);
		end
		apb(1, {`TOFS_IDX_FAN_AVG_CFG, 2'b00}, 32'hFF, r, e);
		apb(0, {`TOFS_IDX_FAN_AVG_CFG, 2'b00}, 0, r, e);
		check("cfg", r, 32'h1F);
		check("cfg outputs", {fan_two_wire_select, averaging_disable}, 5'h1F);
		for (int k = 0; k < 8; k++) begin
			@(negedge mclk);
			check("two-wire pulse", fan_pulse, fp_exp);
			if (k == 3) thr <= 8'h20;
		end
		for (int i = 0; i < 3; i++) begin
			apb(1, {`TOFS_IDX_REMOTE_ONE_OFS + 10'(i), 2'b00}, ofs[i], r, e);
			feed(i, raw[i]);
			check("valid", v, 1);
			check("reading", t, expv[i]);
			apb(0, {`TOFS_IDX_READ_REMOTE_ONE + 10'(i), 2'b00}, 0, r, e);
			check("reading reg", r, expv[i]);
		end
		apb(1, {`TOFS_IDX_LOCK, 2'b00}, 1, r, e);
		for (int i = 0; i < 3; i++) begin
			apb(1, {`TOFS_IDX_REMOTE_ONE_OFS + 10'(i), 2'b00}, 8'h55, r, e);
			apb(0, {`TOFS_IDX_REMOTE_ONE_OFS + 10'(i), 2'b00}, 0, r, e);
			check("locked", r, i == 2 ? 8'h55 : ofs[i]);
		end
		apb(1, {`TOFS_IDX_FAN_AVG_CFG, 2'b00}, 0, r, e);
		for (int k = 0; k < 4; k++) begin
			@(negedge mclk);
			check("three-wire pulse", fan_pulse, fp_exp);
		end
		for (int k = 1; k <= 16; k++) begin
			feed(1, 10'd40);
			check("avg valid", v, k == 16);
		end
		check("avg reading", t, 10'd48);
		apb(0, 12'hFFC, 0, r, e);
		check("unmapped", e, 1);
		close_out();
	end
endmodule : tb_top
